// ### verilog/i2cst_pkg.sv
package i2cst_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_OWN = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_TOC = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  // serial_mode_reg fields
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int MODE_EN_BIT = 1;
  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
  localparam logic [7:0] MODE_RST = 8'he0;
  // serial_status_reg fields
  localparam int ST_DONE_BIT = 7;
  localparam int ST_MATCH_BIT = 6;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_HTX_BIT = 4;
  localparam int ST_ACK_TO_SEND_BIT = 3;
  localparam int ST_SRW_BIT = 2;
  localparam int ST_ACK_RECEIVED_FLAG_BIT = 0;
  // bus_timeout_control fields
  localparam int TOC_EN_BIT = 7;
  localparam int TOC_FLAG_BIT = 6;
  localparam int TOC_SEL_MSB = 5;
  localparam logic [7:0] TOC_RST = 8'h00;
  // irq register fields
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_PEND_BIT = 1;
  // timeout tick is the sub clock divided by this
  localparam int TO_DIV = 32;
  localparam int TO_DIV_W = $clog2(TO_DIV);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    st_idle, st_addr, st_aack, st_hold, st_tx, st_rack, st_rx, st_dack, st_wait
  } i2cst_fsm_t;
endpackage

// ### verilog/i2cst_sync.sv
`timescale 1ns/100ps
module i2cst_sync import i2cst_pkg::*; #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } i2cst_sync_t;
  i2cst_sync_t s_r;
  i2cst_sync_t s_nxt;

  initial begin
    if (W < 1) $error("i2cst_sync: W must be at least 1");
  end

  // a change counts only once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q = ((s_r.s2 ~^ s_r.s3) & s_r.s2) | ((s_r.s2 ^ s_r.s3) & s_r.q);
  end

  // idle bus lines are high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

// ### verilog/i2cst_top.sv
// Overview of operation
// - shift seven address bits, match, flag, interrupt
// - eighth bit stored as master read flag
// - acknowledge matching address on ninth clock
// - start is sda fall, scl high; busy
// - data bytes eight bits, msb first
// - receive ack bit driven from ack_to_send
// - master nak: release sda, await stop
// - hold scl until data write or read
// - transmitter_select picks drive or receive
// - one interrupt: match, byte, or timeout
// - active only when mode 110 and enabled
// - timeout starts on match, scl falls clear
// - timeout expiry: stop, clear enable, flag, irq
// - timeout resets bus logic and status register
// - period is (select+1) times 32 sub clocks
// - timeout flag stays until software writes zero
// - stop clears bus busy flag
// - byte done low while shifting, high after
// - ack received flag samples ninth clock sda
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module i2cst_top import i2cst_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic sub_clk,
  output logic serial_irq
);
  typedef struct packed {
    i2cst_fsm_t st;
    logic [7:0] data;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] own;
    logic [7:0] mode;
    logic [7:0] toc;
    logic byte_done;
    logic addr_match;
    logic busy;
    logic transmitter_select;
    logic ack_to_send;
    logic master_read_flag;
    logic ack_received_flag;
    logic scl_q;
    logic sda_q;
    logic sub_q;
    logic [TO_DIV_W-1:0] div;
    logic [5:0] to_cnt;
    logic to_run;
    logic sda_low;
    logic scl_low;
    logic irq_en;
    logic irq_pend;
    logic [31:0] rdata;
  } i2cst_state_t;
  i2cst_state_t s_r;
  i2cst_state_t s_nxt;

  logic scl_s;
  logic sda_s;
  logic sub_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic active;
  logic wr_ev;
  logic rd_ev;
  logic mapped;
  logic tick;
  logic to_fire;
  logic match_ev;
  logic [7:0] sel_addr;

  initial begin
    if (ADDR_W < 8) $error("i2cst_top: ADDR_W must be at least 8");
  end

  i2cst_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({scl_i, sda_i, sub_clk}),
    .q({scl_s, sda_s, sub_s})
  );

  function automatic logic [7:0] stat_byte(input i2cst_state_t s);
    stat_byte = 8'h00;
    stat_byte[ST_DONE_BIT] = s.byte_done;
    stat_byte[ST_MATCH_BIT] = s.addr_match;
    stat_byte[ST_BUSY_BIT] = s.busy;
    stat_byte[ST_HTX_BIT] = s.transmitter_select;
    stat_byte[ST_ACK_TO_SEND_BIT] = s.ack_to_send;
    stat_byte[ST_SRW_BIT] = s.master_read_flag;
    stat_byte[ST_ACK_RECEIVED_FLAG_BIT] = s.ack_received_flag;
  endfunction

  assign sel_addr = paddr[7:0];
  assign scl_rise = scl_s & ~s_r.scl_q;
  assign scl_fall = ~scl_s & s_r.scl_q;
  assign start_ev = s_r.sda_q & ~sda_s & scl_s & s_r.scl_q;
  assign stop_ev = ~s_r.sda_q & sda_s & scl_s & s_r.scl_q;
  assign active = (s_r.mode[MODE_MSB:MODE_LSB] == MODE_I2C_SLAVE) & s_r.mode[MODE_EN_BIT];
  assign mapped = (paddr[ADDR_W-1:0] <= ADDR_W'(OFS_IRQ)) & (paddr[1:0] == 2'h0);
  assign wr_ev = psel & penable & pwrite & mapped;
  assign rd_ev = psel & penable & ~pwrite & mapped;
  // tick every TO_DIV sub clock rising edges
  assign tick = sub_s & ~s_r.sub_q & (s_r.div == TO_DIV_W'(TO_DIV - 1));
  assign to_fire = active & s_r.to_run & s_r.toc[TOC_EN_BIT] & ~scl_fall & ~stop_ev & tick
                   & (s_r.to_cnt == s_r.toc[TOC_SEL_MSB:0]);
  assign match_ev = (s_r.st == st_addr) & scl_fall & (s_r.cnt == BYTE_BITS)
                    & (s_r.sh[7:1] == s_r.own[7:1]) & ~start_ev & ~stop_ev;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q = scl_s;
    s_nxt.sda_q = sda_s;
    s_nxt.sub_q = sub_s;
    if (sub_s & ~s_r.sub_q) begin
      s_nxt.div = s_r.div + 1'b1;
    end
    // read data staged in the setup phase, so access never waits
    if (psel & ~penable) begin
      s_nxt.rdata = 32'h0000_0000;
      unique case (sel_addr)
        OFS_DATA: s_nxt.rdata[7:0] = s_r.data;
        OFS_OWN: s_nxt.rdata[7:0] = s_r.own;
        OFS_MODE: s_nxt.rdata[7:0] = s_r.mode;
        OFS_STAT: s_nxt.rdata[7:0] = stat_byte(s_r);
        OFS_TOC: s_nxt.rdata[7:0] = s_r.toc;
        OFS_IRQ: s_nxt.rdata[1:0] = {s_r.irq_pend, s_r.irq_en};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // software writes first; hardware events below win
    if (wr_ev) begin
      unique case (sel_addr)
        OFS_DATA: s_nxt.data = pwdata[7:0];
        OFS_OWN: s_nxt.own = pwdata[7:0];
        OFS_MODE: s_nxt.mode = pwdata[7:0] & 8'hef;
        OFS_STAT: begin
          s_nxt.transmitter_select = pwdata[ST_HTX_BIT];
          s_nxt.ack_to_send = pwdata[ST_ACK_TO_SEND_BIT];
          s_nxt.master_read_flag = pwdata[ST_SRW_BIT];
        end
        OFS_TOC: s_nxt.toc = pwdata[7:0];
        OFS_IRQ: begin
          s_nxt.irq_en = pwdata[IRQ_EN_BIT];
          if (pwdata[IRQ_PEND_BIT]) s_nxt.irq_pend = 1'b0;
        end
        default: s_nxt.irq_en = s_r.irq_en;
      endcase
    end
    if (!active) begin
      // flags go to defaults, control bits keep their values
      s_nxt.st = st_idle;
      s_nxt.byte_done = 1'b1;
      s_nxt.addr_match = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.master_read_flag = 1'b0;
      s_nxt.ack_received_flag = 1'b1;
      s_nxt.to_run = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.scl_low = 1'b0;
    end else if (start_ev) begin
      // repeated start restarts the address phase from any state
      s_nxt.st = st_addr;
      s_nxt.busy = 1'b1;
      s_nxt.addr_match = 1'b0;
      s_nxt.cnt = 4'h0;
      s_nxt.sda_low = 1'b0;
      s_nxt.scl_low = 1'b0;
    end else if (stop_ev) begin
      s_nxt.st = st_idle;
      s_nxt.busy = 1'b0;
      s_nxt.to_run = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.scl_low = 1'b0;
    end else begin
      unique case (s_r.st)
        st_idle, st_wait: s_nxt.st = s_r.st;
        st_addr: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_s};
            s_nxt.cnt = s_r.cnt + 1'b1;
          end else if (scl_fall && s_r.cnt == BYTE_BITS) begin
            if (match_ev) begin
              s_nxt.addr_match = 1'b1;
              s_nxt.master_read_flag = s_r.sh[0];
              s_nxt.irq_pend = 1'b1;
              s_nxt.sda_low = 1'b1;
              s_nxt.to_run = 1'b1;
              s_nxt.to_cnt = 6'h00;
              s_nxt.div = '0;
              s_nxt.st = st_aack;
            end else begin
              s_nxt.st = st_wait;
            end
          end
        end
        st_aack, st_dack: begin
          if (scl_fall) begin
            s_nxt.sda_low = 1'b0;
            s_nxt.scl_low = 1'b1;
            s_nxt.st = st_hold;
          end
        end
        st_hold: begin
          if (wr_ev && sel_addr == OFS_DATA && s_r.transmitter_select) begin
            s_nxt.sh = pwdata[7:0];
            s_nxt.sda_low = ~pwdata[7];
            s_nxt.scl_low = 1'b0;
            s_nxt.cnt = 4'h0;
            s_nxt.byte_done = 1'b0;
            s_nxt.st = st_tx;
          end else if (rd_ev && sel_addr == OFS_DATA && !s_r.transmitter_select) begin
            s_nxt.scl_low = 1'b0;
            s_nxt.cnt = 4'h0;
            s_nxt.byte_done = 1'b0;
            s_nxt.st = st_rx;
          end
        end
        st_tx: begin
          if (scl_fall) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt == BYTE_BITS - 4'h1) begin
              s_nxt.sda_low = 1'b0;
              s_nxt.st = st_rack;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_low = ~s_r.sh[6];
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            s_nxt.ack_received_flag = sda_s;
            s_nxt.byte_done = 1'b1;
            s_nxt.irq_pend = 1'b1;
          end else if (scl_fall) begin
            // a nak means the master wants no more data
            s_nxt.st = s_r.ack_received_flag ? st_wait : st_hold;
            s_nxt.scl_low = ~s_r.ack_received_flag;
          end
        end
        st_rx: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_s};
            s_nxt.cnt = s_r.cnt + 1'b1;
          end else if (scl_fall && s_r.cnt == BYTE_BITS) begin
            s_nxt.data = s_r.sh;
            s_nxt.byte_done = 1'b1;
            s_nxt.irq_pend = 1'b1;
            s_nxt.sda_low = ~s_r.ack_to_send;
            s_nxt.st = st_dack;
          end
        end
      endcase
      // timeout counter, cleared by every scl fall
      if (s_r.to_run && s_r.toc[TOC_EN_BIT]) begin
        if (scl_fall) begin
          s_nxt.to_cnt = 6'h00;
        end else if (tick) begin
          s_nxt.to_cnt = s_r.to_cnt + 1'b1;
        end
      end
    end
    if (to_fire) begin
      s_nxt.to_run = 1'b0;
      s_nxt.toc[TOC_EN_BIT] = 1'b0;
      s_nxt.toc[TOC_FLAG_BIT] = 1'b1;
      s_nxt.irq_pend = 1'b1;
      s_nxt.st = st_idle;
      s_nxt.sda_low = 1'b0;
      s_nxt.scl_low = 1'b0;
      s_nxt.byte_done = 1'b1;
      s_nxt.addr_match = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.transmitter_select = 1'b0;
      s_nxt.ack_to_send = 1'b0;
      s_nxt.master_read_flag = 1'b0;
      s_nxt.ack_received_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= st_idle;
      s_r.mode <= MODE_RST;
      s_r.toc <= TOC_RST;
      s_r.byte_done <= 1'b1;
      s_r.ack_received_flag <= 1'b1;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      // synchroniser resets high, so no false sub clock edge
      s_r.sub_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero wait states: read data was staged during setup
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s_r.rdata;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = s_r.scl_low;
  assign sda_oe = s_r.sda_low;
  assign serial_irq = s_r.irq_pend & s_r.irq_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_BUSY: assert property (active && start_ev && !to_fire |=> s_r.busy)
    else $error("start did not set busy");
  AST_STOP_FREE: assert property (active && stop_ev && !to_fire |=> !s_r.busy)
    else $error("stop did not clear busy");
  AST_ADDR_ACK: assert property (match_ev && active && !to_fire
    |=> sda_oe && s_r.addr_match && s_r.irq_pend)
    else $error("matched address not acknowledged");
  AST_SRW: assert property (match_ev && active && !to_fire |=> s_r.master_read_flag == $past(s_r.sh[0]))
    else $error("read flag not captured");
  AST_HOLD_SCL: assert property (s_r.st == st_hold |-> scl_oe)
    else $error("scl not held in hold state");
  AST_TIMEOUT: assert property (to_fire |=> s_r.toc[TOC_FLAG_BIT] && !s_r.toc[TOC_EN_BIT]
    && s_r.byte_done && !s_r.busy && s_r.st == st_idle && !scl_oe)
    else $error("timeout effects missing");
  AST_NAK_WAIT: assert property (active && s_r.st == st_rack && scl_fall && s_r.ack_received_flag
    && !start_ev && !stop_ev && !to_fire |=> s_r.st == st_wait && !sda_oe)
    else $error("nak did not release sda");
  AST_INACTIVE: assert property (!active |=> s_r.st == st_idle && !sda_oe && !scl_oe)
    else $error("slave active while disabled");
  AST_DATA_ACK: assert property (active && s_r.st == st_rx && scl_fall && s_r.cnt == BYTE_BITS
    && !start_ev && !stop_ev && !to_fire |=> sda_oe == !s_r.ack_to_send && s_r.byte_done)
    else $error("data acknowledge wrong");

  COV_MATCH: cover property (match_ev ##[1:200] s_r.st == st_hold);
  COV_TX_BYTE: cover property (s_r.st == st_tx ##[1:400] s_r.st == st_rack);
  COV_RX_BYTE: cover property (s_r.st == st_rx ##[1:400] s_r.st == st_dack);
  COV_TIMEOUT: cover property (to_fire);
endmodule

// ### sim/i2cst_master.sv
`timescale 1ns/100ps
module i2cst_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release scl, tolerate stretching, then keep the high phase
  // 55 low, 25 high: slave answers a fall only through its synchroniser
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 5000 && !scl; i++) #10;
    #25;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    #35;
    rise();
    s = sda;
    scl_low = 1'b1;
    #20;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #20;
    rise();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #20;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #20;
    rise();
    sda_low = 1'b0;
    // give the slave time to see stop before status is read
    #100;
  endtask
  // long low after the ack clock: slave needs time to grab scl
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
    #60;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(ack, s);
    #60;
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/100ps
module tb import i2cst_pkg::*;;
  localparam logic [6:0] ADR = 7'h5a;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sub_clk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl_oe, sda_oe, serial_irq, m_scl_low, m_sda_low, scl, sda;
  logic ack, err;
  logic [7:0] rx;
  int n_errors = 0, checks_done = 0;
  // open-drain wires with pull-ups
  assign scl = !(scl_oe || m_scl_low);
  assign sda = !(sda_oe || m_sda_low);
  i2cst_top #(.ADDR_W(8)) i2cst_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .sub_clk(sub_clk), .serial_irq(serial_irq));
  i2cst_master i2cst_master_i (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    #3;
    // slow enough to pass the three-flop filter
    forever #40 sub_clk = ~sub_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask
  // skip the tail of a previous hold before looking for the next one
  task automatic hold_wait();
    int i;
    repeat (3) @(posedge pclk);
    for (i = 0; i < 3000 && scl_oe !== 1'b1; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check(scl_oe, 1'b1);
    check(serial_irq, 1'b1);
    apb(1'b1, OFS_IRQ, 8'h03);
  endtask
  task automatic t_reset();
    rchk(OFS_STAT, 8'h81);
    rchk(OFS_MODE, MODE_RST);
    rchk(OFS_TOC, TOC_RST);
    apb(1'b0, 8'h18, 8'h00);
    check(err, 1'b1);
    apb(1'b1, OFS_OWN, {ADR, 1'b0});
    apb(1'b1, OFS_MODE, 8'hc2);
    apb(1'b1, OFS_IRQ, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_rx();
    i2cst_master_i.start();
    apb(1'b0, OFS_STAT, 8'h00);
    check(rd[ST_BUSY_BIT], 1'b1);
    i2cst_master_i.wbyte({ADR, 1'b0}, ack);
    check(ack, 1'b0);
    apb(1'b0, OFS_STAT, 8'h00);
    check(rd[ST_MATCH_BIT], 1'b1);
    check(rd[ST_SRW_BIT], 1'b0);
    fork
      begin
        i2cst_master_i.wbyte(8'ha5, ack);
        check(ack, 1'b0);
        i2cst_master_i.wbyte(8'h3c, ack);
        check(ack, 1'b1);
      end
      begin
        hold_wait();
        apb(1'b0, OFS_DATA, 8'h00);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_STAT, 8'h00);
        check(rd[ST_DONE_BIT], 1'b0);
        hold_wait();
        apb(1'b0, OFS_DATA, 8'h00);
        check(rd, 32'ha5);
        apb(1'b1, OFS_STAT, 8'h08);
        hold_wait();
        apb(1'b0, OFS_DATA, 8'h00);
        check(rd, 32'h3c);
      end
    join
    i2cst_master_i.stop();
    apb(1'b0, OFS_STAT, 8'h00);
    check(rd[ST_BUSY_BIT], 1'b0);
    $display("receive test done");
  endtask
  task automatic t_tx();
    i2cst_master_i.start();
    i2cst_master_i.wbyte({ADR, 1'b1}, ack);
    check(ack, 1'b0);
    apb(1'b0, OFS_STAT, 8'h00);
    check(rd[ST_SRW_BIT], 1'b1);
    apb(1'b1, OFS_STAT, 8'h14);
    fork
      begin
        i2cst_master_i.rbyte(1'b0, rx);
        check(rx, 8'hc3);
        i2cst_master_i.rbyte(1'b1, rx);
        check(rx, 8'h5a);
      end
      begin
        hold_wait();
        apb(1'b1, OFS_DATA, 8'hc3);
        hold_wait();
        apb(1'b0, OFS_STAT, 8'h00);
        check(rd[ST_ACK_RECEIVED_FLAG_BIT], 1'b0);
        apb(1'b1, OFS_DATA, 8'h5a);
      end
    join
    repeat (40) @(posedge pclk);
    check({scl_oe, sda_oe}, 2'b00);
    apb(1'b0, OFS_STAT, 8'h00);
    check(rd[ST_ACK_RECEIVED_FLAG_BIT], 1'b1);
    i2cst_master_i.stop();
    $display("transmit test done");
  endtask
  // every other mode, the disabled unit and a foreign address go unanswered
  task automatic t_modes();
    for (int m = 0; m < 9; m++) begin
      apb(1'b1, OFS_MODE, (m < 8) ? {m[2:0], 5'h02} : 8'hc0);
      i2cst_master_i.start();
      i2cst_master_i.wbyte({ADR ^ {6'h0, m == 6}, 1'b0}, ack);
      check(ack, 1'b1);
      i2cst_master_i.stop();
    end
    apb(1'b1, OFS_MODE, 8'hc2);
    $display("mode test done");
  endtask
  task automatic t_timeout();
    apb(1'b1, OFS_TOC, 8'h81);
    i2cst_master_i.start();
    i2cst_master_i.wbyte({ADR, 1'b0}, ack);
    apb(1'b1, OFS_IRQ, 8'h03);
    repeat (30) @(posedge pclk);
    rchk(OFS_TOC, 8'h81);
    repeat (600) @(posedge pclk);
    rchk(OFS_TOC, 8'h41);
    check(scl_oe, 1'b0);
    rchk(OFS_STAT, 8'h81);
    rchk(OFS_MODE, 8'hc2);
    rchk(OFS_IRQ, 8'h03);
    i2cst_master_i.stop();
    rchk(OFS_TOC, 8'h41);
    apb(1'b1, OFS_TOC, 8'h00);
    rchk(OFS_TOC, 8'h00);
    $display("timeout test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    t_modes();
    t_timeout();
    print_verdict();
  end
endmodule
